// ### chp_defines.svh
// constants for the component handler port
`ifndef CHP_DEFINES_SVH
`define CHP_DEFINES_SVH
//
// Overview of operation
// - every result and control output is active low, open collector: asserted means pulled low.
// - in bin mode the measured result is reported on the bin and out lines as good or not good; aux stays released.
// - in list sweep mode each sweep point shows in or out of limit, and aux shows overall fail.
// - analog-test-done is asserted once conversion of the measurement has ended.
// - end-of-measurement is asserted only after the test is done and result lines are valid.
// - the alarm is asserted whenever a break in the measurement circuit is detected.
// - the over-high flag is asserted when the main parameter exceeds the upper limit.
// - the under-low flag is asserted when the main parameter is below the lower limit.
// - the reject flag is asserted when the result lies outside the valid range.
// - with external trigger selected and the port enabled, each trigger pulse of at least 123 cycles starts a measurement unless one is in progress.
// - while the handler port is in use the front-panel keys are locked.
// - key input stays disabled for as long as the handler asserts key lock.
// - after analog-test-done, result lines stay asserted until end-of-measurement too.

// ****************************************************************
// register map
// ****************************************************************
`define CHP_ADDR_CTRL 12'h000
`define CHP_ADDR_RESULT 12'h004
`define CHP_ADDR_STATUS 12'h008
`define CHP_ADDR_INT_STAT 12'h00C
`define CHP_ADDR_INT_MASK 12'h010
`define CHP_ADDR_STEP 12'h014

// ctrl fields
`define CHP_CTRL_ENABLE 0
`define CHP_CTRL_EXTERNAL_TRIGGER_IN 1
`define CHP_CTRL_LIST_MODE 2
`define CHP_CTRL_SW_TRIG 3
`define CHP_CTRL_ALARM 4
`define CHP_CTRL_CONV_DONE 5
`define CHP_CTRL_CMP_DONE 6

// result fields
`define CHP_RES_BIN_LSB 0
`define CHP_RES_BIN_MSB 3
`define CHP_RES_HIGH 4
`define CHP_RES_LOW 5
`define CHP_RES_RANGE 6
`define CHP_RES_POINTS_LSB 8
`define CHP_RES_POINTS_MSB 17
`define CHP_RES_FAIL 18

// interrupt bits
`define CHP_IRQ_TRIG 0
`define CHP_IRQ_INDEX 1
`define CHP_IRQ_EOM 2
`define CHP_IRQ_ALARM 3
`define CHP_IRQ_BITS 4

`define CHP_CTRL_RESET 32'h0000_0000

// trigger pulse width
`define CHP_CLK_MHZ 125
`define CHP_TRIG_MIN_NS 1000
`define CHP_TRIG_MIN_CYC ((`CHP_TRIG_MIN_NS * `CHP_CLK_MHZ + 999) / 1000)
`endif

// ### chp_pkg.sv
// types for the component handler port
package chp_pkg;
  typedef enum logic [2:0] {
    CHP_IDLE,
    CHP_CONVERT,
    CHP_COMPARE,
    CHP_DONE
  } chp_state_t;
  typedef logic [8:0] chp_bins_t;
endpackage

// ### chp_trig_if.sv
// trigger pulse between filter and sequencer
`timescale 1ns/100ps
`default_nettype none
interface chp_trig_if;
  logic start;
  logic level;
  modport src (output start, output level);
  modport dst (input start, input level);
endinterface
`default_nettype wire

// ### chp_trig_filter.sv
// trigger synchroniser and width filter
`timescale 1ns/100ps
`default_nettype none
`include "chp_defines.svh"
module chp_trig_filter
  import chp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic trig_pin,
  chp_trig_if.src trig
);
  localparam int unsigned CW = 8;
  localparam logic [CW-1:0] MINC = CW'(`CHP_TRIG_MIN_CYC);
  logic s1_r, s2_r, s1_nxt, s2_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic qual_r, qual_nxt, start_r, start_nxt;

  // ****************************************************************
  // width qualified rising edge
  // ****************************************************************
  always_comb begin
    s1_nxt = trig_pin;
    s2_nxt = s1_r;
    cnt_nxt = cnt_r;
    qual_nxt = qual_r;
    start_nxt = 1'b0;
    if (!s2_r) begin
      cnt_nxt = '0;
      qual_nxt = 1'b0;
    end else if (!qual_r) begin
      // pulses shorter than the minimum width less two cycles are dropped
      cnt_nxt = cnt_r + CW'(1);
      if (cnt_r + CW'(1) >= MINC - CW'(2)) begin
        qual_nxt = 1'b1;
        start_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      cnt_r <= '0;
      qual_r <= 1'b0;
      start_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      cnt_r <= cnt_nxt;
      qual_r <= qual_nxt;
      start_r <= start_nxt;
    end
  end

  assign trig.start = start_r;
  assign trig.level = s2_r;

  property p_one_start;
    @(posedge clk) disable iff (!rstn) trig.start |=> !trig.start;
  endproperty
  a_one_start: assert property (p_one_start)
    else $error("start longer than one cycle");
  property p_needs_high;
    @(posedge clk) disable iff (!rstn) $rose(trig.start) |-> $past(s2_r);
  endproperty
  a_needs_high: assert property (p_needs_high)
    else $error("start without high input");
endmodule
`default_nettype wire

// ### chp_axil_regs.sv
// axi4-lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "chp_defines.svh"
module chp_axil_regs
  import chp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] ctrl,
  output logic ctrl_we,
  output logic [31:0] result,
  output logic result_we,
  output logic [`CHP_IRQ_BITS-1:0] mask,
  output logic [`CHP_IRQ_BITS-1:0] clr,
  input wire logic [31:0] status,
  input wire logic [`CHP_IRQ_BITS-1:0] istat,
  input wire logic [31:0] step
);
  logic [11:0] aw_r, aw_nxt;
  logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0] ws_r, ws_nxt;
  logic bv_r, bv_nxt, rv_r, rv_nxt;
  logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
  logic [31:0] rd_r, rd_nxt, ctrl_r, ctrl_nxt, res_r, res_nxt;
  logic [`CHP_IRQ_BITS-1:0] mask_r, mask_nxt;
  logic do_wr;
  logic cwe_r, cwe_nxt, rwe_r, rwe_nxt;

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] m;
    m = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        m[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return m;
  endfunction

  assign awready = !aw_ok_r && !bv_r;
  assign wready = !w_ok_r && !bv_r;
  assign arready = !rv_r;
  assign do_wr = aw_ok_r && w_ok_r && !bv_r;

  always_comb begin
    aw_nxt = aw_r;
    aw_ok_nxt = aw_ok_r;
    wd_nxt = wd_r;
    ws_nxt = ws_r;
    w_ok_nxt = w_ok_r;
    bv_nxt = bv_r;
    br_nxt = br_r;
    ctrl_nxt = ctrl_r;
    res_nxt = res_r;
    mask_nxt = mask_r;
    clr = '0;
    cwe_nxt = 1'b0;
    rwe_nxt = 1'b0;
    if (awvalid && awready) begin
      aw_nxt = awaddr;
      aw_ok_nxt = 1'b1;
    end
    if (wvalid && wready) begin
      wd_nxt = wdata;
      ws_nxt = wstrb;
      w_ok_nxt = 1'b1;
    end
    if (do_wr) begin
      aw_ok_nxt = 1'b0;
      w_ok_nxt = 1'b0;
      bv_nxt = 1'b1;
      br_nxt = 2'b00;
      case (aw_r)
        `CHP_ADDR_CTRL: begin
          ctrl_nxt = merge(ctrl_r, wd_r, ws_r);
          cwe_nxt = 1'b1;
        end
        `CHP_ADDR_RESULT: begin
          res_nxt = merge(res_r, wd_r, ws_r);
          rwe_nxt = 1'b1;
        end
        `CHP_ADDR_INT_STAT: clr = ws_r[0] ? wd_r[`CHP_IRQ_BITS-1:0] : '0;
        `CHP_ADDR_INT_MASK: begin
          if (ws_r[0]) begin
            mask_nxt = wd_r[`CHP_IRQ_BITS-1:0];
          end
        end
        `CHP_ADDR_STATUS, `CHP_ADDR_STEP: br_nxt = 2'b00;
        default: br_nxt = 2'b10;
      endcase
    end
    if (bv_r && bready) begin
      bv_nxt = 1'b0;
    end
  end

  always_comb begin
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (arvalid && arready) begin
      rv_nxt = 1'b1;
      rr_nxt = 2'b00;
      case (araddr)
        `CHP_ADDR_CTRL: rd_nxt = ctrl_r;
        `CHP_ADDR_RESULT: rd_nxt = res_r;
        `CHP_ADDR_STATUS: rd_nxt = status;
        `CHP_ADDR_INT_STAT: rd_nxt = 32'(istat);
        `CHP_ADDR_INT_MASK: rd_nxt = 32'(mask_r);
        `CHP_ADDR_STEP: rd_nxt = step;
        default: begin
          rd_nxt = 32'h0000_0000;
          rr_nxt = 2'b10;
        end
      endcase
    end else if (rv_r && rready) begin
      rv_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      aw_r <= '0;
      aw_ok_r <= 1'b0;
      wd_r <= '0;
      ws_r <= '0;
      w_ok_r <= 1'b0;
      bv_r <= 1'b0;
      br_r <= 2'b00;
      rv_r <= 1'b0;
      rd_r <= '0;
      rr_r <= 2'b00;
      ctrl_r <= `CHP_CTRL_RESET;
      res_r <= '0;
      mask_r <= '0;
      cwe_r <= 1'b0;
      rwe_r <= 1'b0;
    end else begin
      aw_r <= aw_nxt;
      aw_ok_r <= aw_ok_nxt;
      wd_r <= wd_nxt;
      ws_r <= ws_nxt;
      w_ok_r <= w_ok_nxt;
      bv_r <= bv_nxt;
      br_r <= br_nxt;
      rv_r <= rv_nxt;
      rd_r <= rd_nxt;
      rr_r <= rr_nxt;
      ctrl_r <= ctrl_nxt;
      res_r <= res_nxt;
      mask_r <= mask_nxt;
      cwe_r <= cwe_nxt;
      rwe_r <= rwe_nxt;
    end
  end

  assign bvalid = bv_r;
  assign bresp = br_r;
  assign rvalid = rv_r;
  assign rdata = rd_r;
  assign rresp = rr_r;
  assign ctrl = ctrl_r;
  assign result = res_r;
  assign mask = mask_r;
  // strobes lag the write so readers see the new word with them
  assign ctrl_we = cwe_r;
  assign result_we = rwe_r;
endmodule
`default_nettype wire

// ### chp_top.sv
// component handler port top: sequencer, result latch, pins
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "chp_defines.svh"
module chp_top
  import chp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic external_trigger_in,
  input wire logic key_lock_n,
  output logic [8:0] sort_bin_lines_oe,
  output logic out_line_oe,
  output logic aux_line_oe,
  output logic over_high_limit_flag_oe,
  output logic under_low_limit_flag_oe,
  output logic range_reject_flag_oe,
  output logic test_done_oe,
  output logic measurement_complete_oe,
  output logic alarm_oe,
  output logic keys_locked,
  output logic irq
);
  chp_trig_if trig();
  logic [31:0] ctrl, result, status, step;
  logic ctrl_we, result_we;
  logic [`CHP_IRQ_BITS-1:0] mask, clr, ist_r, ist_nxt, ev;
  chp_state_t st_r, st_nxt;
  logic [8:0] bins_r, bins_nxt;
  logic out_r, out_nxt, aux_r, aux_nxt;
  logic hi_r, hi_nxt, lo_r, lo_nxt, rej_r, rej_nxt;
  logic idx_r, idx_nxt, eom_r, eom_nxt, alm_r, alm_nxt;
  logic [3:0] step_r, step_nxt;
  logic k1_r, k2_r, start;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  function automatic logic [8:0] bin_dec(input logic [3:0] b);
    logic [8:0] d;
    d = '0;
    if (b >= 4'h1 && b <= 4'h9) begin
      d[b - 4'h1] = 1'b1;
    end
    return d;
  endfunction

  chp_trig_filter u_trig (
    .clk(clk),
    .rstn(rstn),
    .trig_pin(external_trigger_in),
    .trig(trig)
  );

  chp_axil_regs u_regs (
    .clk(clk),
    .rstn(rstn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .ctrl(ctrl),
    .ctrl_we(ctrl_we),
    .result(result),
    .result_we(result_we),
    .mask(mask),
    .clr(clr),
    .status(status),
    .istat(ist_r),
    .step(step)
  );

  // ****************************************************************
  // measurement sequencer
  // ****************************************************************
  assign start = ctrl[`CHP_CTRL_ENABLE] && st_r != CHP_CONVERT &&
                 st_r != CHP_COMPARE &&
                 ((ctrl[`CHP_CTRL_EXTERNAL_TRIGGER_IN] && trig.start) ||
                  (ctrl_we && ctrl[`CHP_CTRL_SW_TRIG]));

  always_comb begin
    st_nxt = st_r;
    bins_nxt = bins_r;
    out_nxt = out_r;
    aux_nxt = aux_r;
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    rej_nxt = rej_r;
    idx_nxt = idx_r;
    eom_nxt = eom_r;
    step_nxt = step_r;
    alm_nxt = ctrl[`CHP_CTRL_ALARM];
    case (st_r)
      CHP_IDLE, CHP_DONE: begin
        if (start) begin
          st_nxt = CHP_CONVERT;
          idx_nxt = 1'b0;
          eom_nxt = 1'b0;
          step_nxt = step_r + 4'h1;
        end
      end
      CHP_CONVERT: begin
        if (ctrl[`CHP_CTRL_CONV_DONE]) begin
          st_nxt = CHP_COMPARE;
          idx_nxt = 1'b1;
        end
      end
      CHP_COMPARE: begin
        // lines update from the result word only here; held otherwise
        if (ctrl[`CHP_CTRL_CMP_DONE] && result_we) begin
          st_nxt = CHP_DONE;
          eom_nxt = 1'b1;
          if (ctrl[`CHP_CTRL_LIST_MODE]) begin
            bins_nxt = result[`CHP_RES_POINTS_LSB +: 9];
            out_nxt = result[`CHP_RES_POINTS_MSB];
            aux_nxt = result[`CHP_RES_FAIL];
          end else begin
            bins_nxt = bin_dec(result[`CHP_RES_BIN_MSB:`CHP_RES_BIN_LSB]);
            out_nxt = bin_dec(result[`CHP_RES_BIN_MSB:`CHP_RES_BIN_LSB])
                      == 9'h000;
            aux_nxt = 1'b0;
          end
          hi_nxt = result[`CHP_RES_HIGH];
          lo_nxt = result[`CHP_RES_LOW];
          rej_nxt = result[`CHP_RES_RANGE];
        end
      end
      default: st_nxt = CHP_IDLE;
    endcase
  end

  // ****************************************************************
  // interrupts: set wins over clear
  // ****************************************************************
  assign ev[`CHP_IRQ_TRIG] = start;
  assign ev[`CHP_IRQ_INDEX] = idx_nxt && !idx_r;
  assign ev[`CHP_IRQ_EOM] = eom_nxt && !eom_r;
  assign ev[`CHP_IRQ_ALARM] = alm_nxt && !alm_r;
  assign ist_nxt = (ist_r & ~clr) | ev;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= CHP_IDLE;
      bins_r <= '0;
      out_r <= 1'b0;
      aux_r <= 1'b0;
      hi_r <= 1'b0;
      lo_r <= 1'b0;
      rej_r <= 1'b0;
      idx_r <= 1'b0;
      eom_r <= 1'b0;
      alm_r <= 1'b0;
      step_r <= '0;
      ist_r <= '0;
      k1_r <= 1'b0;
      k2_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bins_r <= bins_nxt;
      out_r <= out_nxt;
      aux_r <= aux_nxt;
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      rej_r <= rej_nxt;
      idx_r <= idx_nxt;
      eom_r <= eom_nxt;
      alm_r <= alm_nxt;
      step_r <= step_nxt;
      ist_r <= ist_nxt;
      k1_r <= ~key_lock_n;
      k2_r <= k1_r;
    end
  end

  // ****************************************************************
  // pins: enable high pulls the isolated line low
  // ****************************************************************
  assign sort_bin_lines_oe = bins_r;
  assign out_line_oe = out_r;
  assign aux_line_oe = aux_r;
  assign over_high_limit_flag_oe = hi_r;
  assign under_low_limit_flag_oe = lo_r;
  assign range_reject_flag_oe = rej_r;
  assign test_done_oe = idx_r;
  assign measurement_complete_oe = eom_r;
  assign alarm_oe = alm_r;
  assign keys_locked = k2_r || ctrl[`CHP_CTRL_ENABLE];
  assign irq = |(ist_r & mask);
  assign status = {22'h00_0000, trig.level, k2_r, alm_r, eom_r, idx_r,
                   1'b0, 1'(st_r == CHP_CONVERT || st_r == CHP_COMPARE),
                   3'(st_r)};
  assign step = {28'h000_0000, step_r};

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_convert_end;
    st_r == CHP_CONVERT && ctrl[`CHP_CTRL_CONV_DONE];
  endsequence
  sequence s_compare_end;
    st_r == CHP_COMPARE && ctrl[`CHP_CTRL_CMP_DONE] && result_we;
  endsequence

  property p_lines_hold;
    (st_r != CHP_COMPARE) |=> $stable(bins_r) && $stable(out_r) &&
    $stable(hi_r);
  endproperty
  a_lines_hold: assert property (p_lines_hold)
    else $error("result lines changed outside compare");

  property p_eom_after_idx;
    $rose(eom_r) |-> idx_r;
  endproperty
  a_eom_after_idx: assert property (p_eom_after_idx)
    else $error("eom without test done");

  property p_idx_conv;
    $rose(idx_r) |-> $past(st_r) == CHP_CONVERT;
  endproperty
  a_idx_conv: assert property (p_idx_conv)
    else $error("test done not from conversion");

  property p_start_go;
    start |=> st_r == CHP_CONVERT && !eom_r;
  endproperty
  a_start_go: assert property (p_start_go)
    else $error("no start");

  property p_hold_idx;
    (st_r == CHP_COMPARE && !eom_r) |-> idx_r;
  endproperty
  a_hold_idx: assert property (p_hold_idx)
    else $error("test done dropped early");

  property p_alarm;
    ctrl[`CHP_CTRL_ALARM] |=> alm_r;
  endproperty
  a_alarm: assert property (p_alarm)
    else $error("alarm missed");

  property p_keys;
    k2_r |-> keys_locked;
  endproperty
  a_keys: assert property (p_keys)
    else $error("keys not locked");

  property p_flags;
    $rose(eom_r) |-> hi_r == $past(result[`CHP_RES_HIGH]) &&
    lo_r == $past(result[`CHP_RES_LOW]) &&
    rej_r == $past(result[`CHP_RES_RANGE]);
  endproperty
  a_flags: assert property (p_flags)
    else $error("flag mismatch");

  property p_index_step;
    s_convert_end |=> idx_r && st_r == CHP_COMPARE;
  endproperty
  a_index_step: assert property (p_index_step)
    else $error("test done late");

  property p_eom_step;
    s_compare_end |=> eom_r && st_r == CHP_DONE;
  endproperty
  a_eom_step: assert property (p_eom_step)
    else $error("eom late");

  property p_enable_locks;
    ctrl[`CHP_CTRL_ENABLE] |-> keys_locked;
  endproperty
  a_enable_locks: assert property (p_enable_locks)
    else $error("keys open while port in use");

  property p_bin_onehot;
    $rose(eom_r) && !$past(ctrl[`CHP_CTRL_LIST_MODE]) |->
    $onehot0(bins_r) && out_r == (bins_r == 9'h000);
  endproperty
  a_bin_onehot: assert property (p_bin_onehot)
    else $error("bin lines not one sorted result");
endmodule
`default_nettype wire

// ### chp_handler_model.sv
// handler machine model: trigger, key lock and pulled-up result lines
`timescale 1ns/100ps
`default_nettype none
module chp_handler_model (
  input wire logic clk,
  input wire logic [16:0] oe,
  output logic trig,
  output logic key_lock_n,
  output logic [16:0] lvl
);
  // ****************************************************************
  // open-collector lines, pulled up by the handler
  // ****************************************************************
  assign lvl = ~oe;
  initial begin
    trig = 1'b0;
    key_lock_n = 1'b1;
  end
  // shorter pulses are dropped by the width filter, so never send one
  task automatic pulse(input int cyc);
    trig <= 1'b1;
    repeat ((cyc < 125) ? 125 : cyc) @(posedge clk);
    trig <= 1'b0;
  endtask
  task automatic lock(input logic on);
    key_lock_n <= ~on;
  endtask
endmodule
`default_nettype wire

// ### component_handler_port_tb.sv
// self-checking bench for the handler port
`timescale 1ns/100ps
`default_nettype none
`include "chp_defines.svh"
module component_handler_port_tb
  import chp_pkg::*;
;
  localparam logic [31:0] RUN = 32'h0000_0003;
  localparam logic [31:0] CONV = 32'h0000_0020;
  localparam logic [31:0] CMP = 32'h0000_0040;
  localparam logic [31:0] LIST = 32'h0000_0004;
  localparam int TD = 14;
  localparam int EOMB = 15;
  localparam int ALM = 16;
  localparam int SIG_KEYS = 0;
  localparam int SIG_IRQ = 1;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic trig, key_lock_n, keys_locked, irq;
  wire [16:0] oe;
  wire [16:0] lvl;
  int bad_count, compares;

  chp_top DUT (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .external_trigger_in(trig), .key_lock_n(key_lock_n),
    .sort_bin_lines_oe(oe[8:0]), .out_line_oe(oe[9]),
    .aux_line_oe(oe[10]), .over_high_limit_flag_oe(oe[11]),
    .under_low_limit_flag_oe(oe[12]), .range_reject_flag_oe(oe[13]),
    .test_done_oe(oe[14]), .measurement_complete_oe(oe[15]),
    .alarm_oe(oe[16]), .keys_locked(keys_locked), .irq(irq));
  chp_handler_model u_hnd (.clk(clk), .oe(oe), .trig(trig),
    .key_lock_n(key_lock_n), .lvl(lvl));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************************************
  // compare, bus and closing tasks
  // ****************************************************************
  task automatic end_sim();
    $display("mismatches %0d compares %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // expected value is the set of asserted (pulled low) lines
  task automatic chk_lines(input logic [16:0] exp);
    compares++;
    if (~lvl !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, ~lvl, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 1000) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        resp = bresp;
        done = 1'b1;
        bready <= 1'b0;
      end
    end
    chk_w({31'h0, done}, 32'h0000_0001);
    @(posedge clk);
  endtask
  task automatic rdr(input logic [11:0] a);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 1000) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        rd = rdata;
        resp = rresp;
        done = 1'b1;
        rready <= 1'b0;
      end
    end
    chk_w({31'h0, done}, 32'h0000_0001);
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    rdr(a);
    chk_w(rd, exp);
  endtask
  task automatic wait_ln(input int b, input logic v);
    int n;
    n = 0;
    while (lvl[b] !== ~v && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk_w({31'h0, ~lvl[b]}, {31'h0, v});
  endtask
  // reads the output after the wait; a copied argument would be stale
  task automatic chk_sig(input int k, input logic exp);
    logic [1:0] v;
    repeat (3) @(posedge clk);
    v = {irq, keys_locked};
    chk_w({31'h0, v[k]}, {31'h0, exp});
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic meas(input logic [31:0] mode, input logic [31:0] res,
                      input logic [13:0] exp);
    logic [13:0] prev;
    wr(`CHP_ADDR_CTRL, mode | RUN);
    prev = ~lvl[13:0];
    u_hnd.pulse(130);
    repeat (8) @(posedge clk);
    chk_lines({3'b000, prev});
    wr(`CHP_ADDR_CTRL, mode | RUN | CONV);
    wait_ln(TD, 1'b1);
    chk_lines({3'b001, prev});
    wr(`CHP_ADDR_CTRL, mode | RUN | CONV | CMP);
    wr(`CHP_ADDR_RESULT, res);
    wait_ln(EOMB, 1'b1);
    chk_lines({3'b011, exp});
    wr(`CHP_ADDR_CTRL, mode | RUN);
    repeat (20) @(posedge clk);
    chk_lines({3'b011, exp});
  endtask
  task automatic t_reset();
    chk_lines(17'h0_0000);
    chk_sig(SIG_KEYS, 1'b0);
    chk_sig(SIG_IRQ, 1'b0);
    rchk(`CHP_ADDR_CTRL, `CHP_CTRL_RESET);
    rchk(`CHP_ADDR_INT_STAT, 32'h0000_0000);
  endtask
  task automatic t_keys();
    u_hnd.lock(1'b1);
    chk_sig(SIG_KEYS, 1'b1);
    rchk(`CHP_ADDR_STATUS, 32'h0000_0100);
    u_hnd.lock(1'b0);
    chk_sig(SIG_KEYS, 1'b0);
    wr(`CHP_ADDR_CTRL, 32'h0000_0001);
    chk_sig(SIG_KEYS, 1'b1);
    // internal trigger selected: the pin must not start anything
    u_hnd.pulse(130);
    repeat (8) @(posedge clk);
    rchk(`CHP_ADDR_INT_STAT, 32'h0000_0000);
    wr(`CHP_ADDR_CTRL, 32'h0000_0000);
  endtask
  task automatic t_meas();
    for (int n = 1; n <= 10; n++) begin
      meas(32'h0, n, (n < 10) ? 14'(1 << (n - 1)) : 14'h0200);
    end
    meas(32'h0, 32'h0000_0015, 14'h0810);
    meas(32'h0, 32'h0000_0060, 14'h3200);
    meas(LIST, 32'h0007_5500, 14'h0755);
    meas(LIST, 32'h0000_0000, 14'h0000);
  endtask
  task automatic t_irq();
    rchk(`CHP_ADDR_INT_STAT, 32'h0000_0007);
    chk_sig(SIG_IRQ, 1'b0);
    wr(`CHP_ADDR_INT_MASK, 32'h0000_0004);
    chk_sig(SIG_IRQ, 1'b1);
    wr(`CHP_ADDR_INT_STAT, 32'h0000_0007);
    chk_sig(SIG_IRQ, 1'b0);
    rchk(`CHP_ADDR_INT_STAT, 32'h0000_0000);
    // software trigger, then the measurement counter
    wr(`CHP_ADDR_CTRL, 32'h0000_0009);
    rchk(`CHP_ADDR_INT_STAT, 32'h0000_0001);
    rchk(`CHP_ADDR_STEP, 32'h0000_000f);
    wr(`CHP_ADDR_INT_STAT, 32'h0000_0001);
    wr(`CHP_ADDR_INT_MASK, 32'h0000_0000);
    wr(`CHP_ADDR_CTRL, 32'h0000_0010);
    wait_ln(ALM, 1'b1);
    rchk(`CHP_ADDR_INT_STAT, 32'h0000_0008);
    chk_sig(SIG_IRQ, 1'b0);
    wr(`CHP_ADDR_INT_MASK, 32'h0000_0008);
    chk_sig(SIG_IRQ, 1'b1);
    wr(`CHP_ADDR_INT_STAT, 32'h0000_0008);
    chk_sig(SIG_IRQ, 1'b0);
    wr(`CHP_ADDR_CTRL, 32'h0000_0000);
    wait_ln(ALM, 1'b0);
  endtask
  task automatic t_map();
    wr(12'h020, 32'h0000_0001);
    chk_w({30'h0, resp}, 32'h0000_0002);
    rdr(12'h020);
    chk_w(rd, 32'h0000_0000);
    chk_w({30'h0, resp}, 32'h0000_0002);
    wr(`CHP_ADDR_STATUS, 32'hffff_ffff);
    chk_w({30'h0, resp}, 32'h0000_0000);
  endtask

  initial begin
    rstn = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    bad_count = 0;
    compares = 0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_keys();
    t_meas();
    t_irq();
    t_map();
    end_sim();
  end
  // whole run is some 3000 cycles; 25000 leaves a wide margin
  initial begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule
`default_nettype wire
